// ### sotp_pkg.sv
package sotp_pkg;

	// Opcodes handled by this block
	localparam logic [7:0] OP_ENTER_OTP  = 8'hb1;
	localparam logic [7:0] OP_EXIT_OTP   = 8'hc1;
	localparam logic [7:0] OP_READ_LOCK  = 8'h2b;
	localparam logic [7:0] OP_WRITE_LOCK = 8'h2f;
	localparam logic [7:0] OP_WRITE_SR1  = 8'h01;
	localparam logic [7:0] OP_WRITE_SR2  = 8'h31;
	localparam logic [7:0] OP_READ_SR1   = 8'h05;
	localparam logic [7:0] OP_READ_SR2   = 8'h35;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FAST_READ  = 8'h0b;
	localparam logic [7:0] OP_PROGRAM    = 8'h02;
	localparam logic [7:0] OP_WREN       = 8'h06;
	localparam logic [7:0] OP_WRDI       = 8'h04;

	// Secure region map, byte addresses
	localparam logic [8:0] ESN_FIRST  = 9'h000;
	localparam logic [8:0] ESN_LAST   = 9'h00f;
	localparam logic [8:0] USER_FIRST = 9'h010;
	localparam logic [8:0] USER_LAST  = 9'h1ff;
	localparam int         OTP_BYTES  = 512;
	localparam logic [7:0] OTP_ERASED = 8'hff;

	// Lock-status register layout
	localparam int         LOCK_FACT_BIT = 0;
	localparam int         LOCK_CUST_BIT = 1;
	localparam logic [7:0] LOCK_RESERVED = 8'h00;

	// Frame layout
	localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
	localparam logic [2:0] BIT_LAST       = 3'h7;

	// Pin synchroniser order and reset levels: {cust_nv, fact, mosi, csn, sck}
	localparam int         PIN_W   = 5;
	localparam logic [4:0] PIN_RST = 5'h02;

	typedef enum logic [3:0]
	{
		ST_CMD    = 4'b0000,
		ST_ADDR   = 4'b0001,
		ST_DUMMY  = 4'b0010,
		ST_RDATA  = 4'b0011,
		ST_WDATA  = 4'b0100,
		ST_LSREAD = 4'b0101,
		ST_LSDATA = 4'b0110,
		ST_LSHELD = 4'b0111,
		ST_IGNORE = 4'b1000
	} sotp_state_e;

endpackage

// ### sotp_sync.sv
// Two-flop synchroniser for a group of pins
module sotp_sync
#(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
)
(
	input  wire logic         i_core_clk,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			meta <= RST_VAL;
			o_q  <= RST_VAL;
		end
		else
		begin
			meta <= i_d;
			o_q  <= meta;
		end
	end

endmodule

// ### sotp_access.sv
module sotp_access
#(
	parameter int OTP_DEPTH = sotp_pkg::OTP_BYTES
)
(
	input  wire logic       i_core_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_spi_sck,
	input  wire logic       i_spi_csn,
	input  wire logic       i_spi_mosi,
	input  wire logic       i_factory_lock,
	input  wire logic       i_customer_lock_nv,
	output logic            o_spi_miso,
	output logic            o_spi_miso_oe_n,
	output logic            o_otp_mode,
	output logic            o_main_write_block,
	output logic            o_cmd_reject,
	output logic      [7:0] o_lock_status
);
	import sotp_pkg::*;

	localparam int AW = $clog2(OTP_DEPTH);

	////////////////////////////////////////////////////////////////////////////////
	// Pin sampling

	logic [PIN_W-1:0] pin_q;
	logic             sck_d;
	logic             csn_d;

	sotp_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync
	(
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_d        ({i_customer_lock_nv, i_factory_lock, i_spi_mosi, i_spi_csn, i_spi_sck}),
		.o_q        (pin_q)
	);

	wire sck_s    = pin_q[0];
	wire csn_s    = pin_q[1];
	wire mosi_s   = pin_q[2];
	wire fact_s   = pin_q[3];
	wire custnv_s = pin_q[4];

	// Clock edges only count inside a frame
	wire sck_rise = sck_s & ~sck_d & ~csn_s;
	wire sck_fall = ~sck_s & sck_d & ~csn_s;
	wire cs_rise  = csn_s & ~csn_d;

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sck_d <= 1'b0;
			csn_d <= 1'b1;
		end
		else
		begin
			sck_d <= sck_s;
			csn_d <= csn_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit and byte assembly

	logic [2:0]  bit_cnt;
	logic [7:0]  rx_sh;
	logic [1:0]  addr_cnt;
	logic [7:0]  cur_op;
	sotp_state_e state;
	sotp_state_e next_state;

	wire [7:0] rx_byte   = {rx_sh[6:0], mosi_s};
	wire       byte_done = sck_rise && (bit_cnt == BIT_LAST);
	wire       cmd_done  = byte_done && (state == ST_CMD);
	wire       addr_done = byte_done && (state == ST_ADDR) && (addr_cnt == ADDR_LAST_BYTE);

	// Mode 0 and 3 both sample on the rising edge
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			bit_cnt  <= 3'h0;
			rx_sh    <= 8'h00;
			addr_cnt <= 2'h0;
			cur_op   <= 8'h00;
		end
		else if (csn_s)
		begin
			bit_cnt  <= 3'h0;
			addr_cnt <= 2'h0;
		end
		else if (sck_rise)
		begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_sh   <= rx_byte;
			if (cmd_done)
				cur_op <= rx_byte;
			if (byte_done && (state == ST_ADDR))
				addr_cnt <= addr_cnt + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic otp_mode;
	logic cust_set;
	logic wel;

	wire cust_lock     = custnv_s | cust_set;
	wire region_locked = fact_s | cust_lock;
	wire op_is_read    = (rx_byte == OP_READ) || (rx_byte == OP_FAST_READ) ||
	                     (rx_byte == OP_READ_LOCK) || (rx_byte == OP_READ_SR1) ||
	                     (rx_byte == OP_READ_SR2);
	wire op_sr_write   = (rx_byte == OP_WRITE_SR1) || (rx_byte == OP_WRITE_SR2);
	wire op_otp_access = (rx_byte == OP_READ) || (rx_byte == OP_FAST_READ) ||
	                     (rx_byte == OP_PROGRAM);
	// Exit stays usable after lockdown, or the host would be stuck in the region
	wire lockdown_drop = otp_mode && region_locked && !op_is_read &&
	                     (rx_byte != OP_EXIT_OTP);
	wire lock_wr_drop  = otp_mode && (op_sr_write || (rx_byte == OP_WRITE_LOCK));
	wire reject_now    = cmd_done && (lockdown_drop || lock_wr_drop);
	wire cmd_take      = cmd_done && !lockdown_drop && !lock_wr_drop;

	// Frame sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			ST_CMD:
			begin
				if (cmd_done)
				begin
					if (!cmd_take)
						next_state = ST_IGNORE;
					else if (rx_byte == OP_READ_LOCK)
						next_state = ST_LSREAD;
					else if (rx_byte == OP_WRITE_LOCK)
						next_state = ST_LSDATA;
					else if (otp_mode && op_otp_access)
						next_state = ST_ADDR;
					else
						next_state = ST_IGNORE;
				end
			end
			ST_ADDR:
			begin
				if (addr_done)
				begin
					if (cur_op == OP_FAST_READ)
						next_state = ST_DUMMY;
					else if (cur_op == OP_PROGRAM)
						next_state = ST_WDATA;
					else
						next_state = ST_RDATA;
				end
			end
			ST_DUMMY:
			begin
				if (byte_done)
					next_state = ST_RDATA;
			end
			ST_LSDATA:
			begin
				if (byte_done)
					next_state = ST_LSHELD;
			end
			ST_RDATA, ST_WDATA, ST_LSREAD, ST_LSHELD, ST_IGNORE:
				next_state = state;
			default:
				next_state = ST_IGNORE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			state <= ST_CMD;
		else if (csn_s)
			state <= ST_CMD;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode, write enable and lock flags

	// Only B1h sets the mode; nothing survives reset
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			otp_mode <= 1'b0;
		else if (cmd_take && (rx_byte == OP_ENTER_OTP))
			otp_mode <= 1'b1;
		else if (cmd_take && (rx_byte == OP_EXIT_OTP))
			otp_mode <= 1'b0;
	end

	// Latch armed by 06h, spent by the end of a program frame
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			wel <= 1'b0;
		else if (cmd_take && (rx_byte == OP_WREN))
			wel <= 1'b1;
		else if ((cmd_take && (rx_byte == OP_WRDI)) || (cs_rise && (state == ST_WDATA)))
			wel <= 1'b0;
	end

	logic [7:0] ls_data;

	// Customer lock is committed only when select rises on a byte boundary
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ls_data  <= 8'h00;
			cust_set <= 1'b0;
		end
		else
		begin
			if (byte_done && (state == ST_LSDATA))
				ls_data <= rx_byte;
			if (cs_rise && (state == ST_LSHELD) && (bit_cnt == 3'h0) && !cust_lock)
				cust_set <= ls_data[LOCK_CUST_BIT];
		end
	end

	// Reserved bits read as zero; bit 0 mirrors the factory fuse only
	logic [7:0] lock_status;
	always_comb
	begin
		lock_status                = LOCK_RESERVED;
		lock_status[LOCK_FACT_BIT] = fact_s;
		lock_status[LOCK_CUST_BIT] = cust_lock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Secure region storage

	logic [7:0]    otp_mem [OTP_DEPTH];
	logic [AW-1:0] addr;
	logic [7:0]    rd_byte;

	// Index equals byte address: serial number low, user data above
	// Every address byte shifts in, so the top index bit comes from the middle byte
	wire [AW+7:0]  addr_cat  = {addr, rx_byte};
	wire [AW-1:0]  addr_load = addr_cat[AW-1:0];
	wire [AW-1:0]  addr_inc  = AW'(addr + 1'b1);
	wire           prog_byte = byte_done && (state == ST_WDATA) && wel &&
	                           !region_locked;

	// Programming can only clear bits, as a fused array would
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			for (int i = 0; i < OTP_DEPTH; i++)
				otp_mem[i] <= OTP_ERASED;
		end
		else if (prog_byte)
			otp_mem[addr] <= otp_mem[addr] & rx_byte;
	end

	// Next byte to send is staged before its first bit leaves
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			addr    <= '0;
			rd_byte <= 8'h00;
		end
		else if (byte_done && (state == ST_ADDR))
		begin
			addr    <= addr_load;
			rd_byte <= otp_mem[addr_load];
		end
		else if (byte_done && ((state == ST_RDATA) || (state == ST_WDATA)))
		begin
			addr    <= addr_inc;
			rd_byte <= otp_mem[addr_inc];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial output

	logic [7:0] tx_sh;
	wire        tx_active = (state == ST_RDATA) || (state == ST_LSREAD);
	// Lock status is fetched fresh for every byte, so a change shows from the next byte
	wire [7:0]  tx_src    = (state == ST_LSREAD) ? lock_status : rd_byte;

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_spi_miso      <= 1'b0;
			o_spi_miso_oe_n <= 1'b1;
			tx_sh           <= 8'h00;
		end
		else if (csn_s)
		begin
			o_spi_miso      <= 1'b0;
			o_spi_miso_oe_n <= 1'b1;
		end
		else if (sck_fall && tx_active)
		begin
			o_spi_miso_oe_n <= 1'b0;
			if (bit_cnt == 3'h0)
			begin
				o_spi_miso <= tx_src[7];
				tx_sh      <= {tx_src[6:0], 1'b0};
			end
			else
			begin
				o_spi_miso <= tx_sh[7];
				tx_sh      <= {tx_sh[6:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status outputs

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_otp_mode         <= 1'b0;
			o_main_write_block <= 1'b0;
			o_cmd_reject       <= 1'b0;
			o_lock_status      <= LOCK_RESERVED;
		end
		else
		begin
			o_otp_mode         <= otp_mode;
			o_main_write_block <= otp_mode;
			o_cmd_reject       <= reject_now;
			o_lock_status      <= lock_status;
		end
	end

endmodule

// ### sotp_access_assertions.sv
module sotp_access_assertions
#(
	parameter int OTP_DEPTH = 512
)
(
	input wire logic       i_core_clk,
	input wire logic       i_resetn,
	input wire logic       i_spi_csn,
	input wire logic       i_factory_lock,
	input wire logic       i_customer_lock_nv,
	input wire logic       o_spi_miso,
	input wire logic       o_spi_miso_oe_n,
	input wire logic       o_otp_mode,
	input wire logic       o_main_write_block,
	input wire logic       o_cmd_reject,
	input wire logic [7:0] o_lock_status
);
	import sotp_pkg::*;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	////////////////////////////////
	// Write guard must track secure mode exactly
	chk_block_mirror: assert property (o_main_write_block == o_otp_mode)
		else $error("write block differs from secure mode");
	chk_reserved_zero: assert property (o_lock_status[7:2] == LOCK_RESERVED[7:2])
		else $error("reserved lock bits not zero");
	// Six steady cycles cover the pin synchroniser
	chk_fact_live: assert property ($stable(i_factory_lock)[*6] |-> o_lock_status[0] == i_factory_lock)
		else $error("factory bit wrong");
	chk_cust_fuse: assert property (i_customer_lock_nv[*6] |-> o_lock_status[1])
		else $error("customer fuse not shown");
	chk_cust_sticky: assert property (o_lock_status[1] |=> o_lock_status[1])
		else $error("customer lock cleared");
	chk_reject_mode: assert property (o_cmd_reject |-> o_otp_mode)
		else $error("reject outside secure mode");
	chk_reject_pulse: assert property (o_cmd_reject |=> !o_cmd_reject[*7])
		else $error("reject not a lone pulse");
	// Mode flips only from an opcode inside a frame
	chk_mode_frame: assert property ($changed(o_otp_mode) |-> !$past(i_spi_csn, 3))
		else $error("mode changed outside a frame");
	chk_idle_release: assert property (i_spi_csn[*5] |-> o_spi_miso_oe_n && !o_spi_miso)
		else $error("data line driven while deselected");
	cov_enter: cover property ($rose(o_otp_mode));
	cov_reject: cover property (o_cmd_reject);
	cov_drive: cover property ($fell(o_spi_miso_oe_n));
	cov_lock: cover property ($rose(o_lock_status[1]));
endmodule
bind sotp_access sotp_access_assertions #(.OTP_DEPTH(OTP_DEPTH)) sotp_access_assertions_i (
	.i_core_clk, .i_resetn, .i_spi_csn, .i_factory_lock, .i_customer_lock_nv, .o_spi_miso,
	.o_spi_miso_oe_n, .o_otp_mode, .o_main_write_block, .o_cmd_reject, .o_lock_status
);

// ### sotp_host_model.sv
module sotp_host_model
(
	input  wire logic i_core_clk,
	input  wire logic i_spi_miso,
	output logic      o_spi_sck,
	output logic      o_spi_csn,
	output logic      o_spi_mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	int slow = 0;
	// Idle: clock low, deselected
	initial
	begin
		o_spi_sck = 1'b0;
		o_spi_csn = 1'b1;
		o_spi_mosi = 1'b0;
	end
	////////////////////////////////
	// Mode 0 bit, eight core cycles; data read at the rise
	task automatic bit_x(input logic b, output logic r);
		@(posedge i_core_clk);
		o_spi_sck <= 1'b0;
		o_spi_mosi <= b;
		repeat (4) @(posedge i_core_clk);
		r = i_spi_miso;
		o_spi_sck <= 1'b1;
		repeat (3) @(posedge i_core_clk);
	endtask
	// Whole bytes, MSB first; slow stretches the clock high
	task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		repeat (slow) @(posedge i_core_clk);
	endtask
	task automatic open_frame();
		@(posedge i_core_clk);
		o_spi_csn <= 1'b0;
		repeat (3) @(posedge i_core_clk);
	endtask
	// Line flipped on release so a stale level never reads as data
	task automatic close_frame();
		@(posedge i_core_clk);
		o_spi_sck <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		o_spi_csn <= 1'b1;
		o_spi_mosi <= ~o_spi_mosi;
		repeat (8) @(posedge i_core_clk);
	endtask
endmodule

// ### test_secured_otp_access_control.sv
module test_secured_otp_access_control;
	timeunit 1ns;
	timeprecision 1ps;
	import sotp_pkg::*;
	logic       i_core_clk = 1'b0;
	logic       i_resetn, i_spi_sck, i_spi_csn, i_spi_mosi;
	logic       i_factory_lock, i_customer_lock_nv;
	logic       o_spi_miso, o_spi_miso_oe_n, o_otp_mode, o_main_write_block, o_cmd_reject;
	logic [7:0] o_lock_status, q;
	logic [7:0] wq[$];
	logic [7:0] rq[$];
	logic [7:0] bad[3] = '{OP_WRITE_SR1, OP_WRITE_SR2, OP_WRITE_LOCK};
	logic [7:0] lk[4] = '{OP_WREN, OP_PROGRAM, OP_WRITE_LOCK, OP_WRDI};
	int         mem[512];
	int         adr[3] = '{15, 511, 0};
	int         rejects, seen_rej, cust, num_errors, check_count;
	always #20 i_core_clk = ~i_core_clk;
	sotp_access #(.OTP_DEPTH(512)) sotp_access_i (.i_core_clk, .i_resetn, .i_spi_sck,
		.i_spi_csn, .i_spi_mosi, .i_factory_lock, .i_customer_lock_nv, .o_spi_miso,
		.o_spi_miso_oe_n, .o_otp_mode, .o_main_write_block, .o_cmd_reject, .o_lock_status);
	// Released line reads inverted, so a missing output enable shows as bad data
	wire        miso_line = o_spi_miso_oe_n ? ~o_spi_miso : o_spi_miso;
	sotp_host_model sotp_host_model_i (.i_core_clk, .i_spi_miso(miso_line),
		.o_spi_sck(i_spi_sck), .o_spi_csn(i_spi_csn), .o_spi_mosi(i_spi_mosi));
	// Reject pulses last one cycle, so count every edge
	always @(posedge i_core_clk)
		if (o_cmd_reject === 1'b1)
			seen_rej++;
	////////////////////////////////
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One frame: opcode, optional address, n data bytes from wq (ff when empty)
	task automatic xfer(input logic [7:0] op, input int a, input int n);
		rq = {};
		sotp_host_model_i.open_frame();
		sotp_host_model_i.byte_x(op, q);
		if (a >= 0)
			for (int i = 2; i >= 0; i--)
				sotp_host_model_i.byte_x(8'(a >> (8 * i)), q);
		for (int i = 0; i < n; i++)
		begin
			sotp_host_model_i.byte_x((i < wq.size()) ? wq[i] : 8'hff, q);
			rq.push_back(q);
		end
		sotp_host_model_i.close_frame();
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		#3000000;
		num_errors++;
		wrap_up();
	end
	initial
	begin
		i_resetn = 1'b0;
		i_factory_lock = 1'b0;
		i_customer_lock_nv = 1'b0;
		foreach (mem[i]) mem[i] = 255;
		void'($urandom(32'h3432));
		adr[2] = $urandom_range(16, 510);
		repeat (20) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		check("mode", 8'h00, {7'h0, o_otp_mode});
		check("status", 8'h00, o_lock_status);
		for (int f = 0; f < 2; f++)
		begin
			i_factory_lock <= f[0];
			sotp_host_model_i.slow = 8 * f;
			xfer(OP_READ_LOCK, -1, 3);
			foreach (rq[k]) check("lock byte", {7'h0, f[0]}, rq[k]);
		end
		i_factory_lock <= 1'b0;
		xfer(OP_ENTER_OTP, -1, 0);
		check("mode", 8'h01, {7'h0, o_otp_mode});
		check("write block", 8'h01, {7'h0, o_main_write_block});
		// Program and read back, across the serial number edge and the wrap
		foreach (adr[j])
		begin
			wq = {8'($urandom), 8'($urandom)};
			xfer(OP_WREN, -1, 0);
			xfer(OP_PROGRAM, adr[j], 2);
			for (int k = 0; k < 2; k++) mem[(adr[j] + k) % 512] &= wq[k];
			wq = {};
			xfer(OP_READ, adr[j], 2);
			for (int k = 0; k < 2; k++) check("otp", 8'(mem[(adr[j] + k) % 512]), rq[k]);
		end
		xfer(OP_FAST_READ, 0, 3);
		check("fast", 8'(mem[0]), rq[1]);
		foreach (bad[j])
		begin
			xfer(bad[j], -1, 1);
			rejects++;
			check("rejects", 8'(rejects), 8'(seen_rej));
		end
		check("status", 8'h00, o_lock_status);
		xfer(OP_EXIT_OTP, -1, 0);
		check("mode", 8'h00, {7'h0, o_otp_mode});
		check("write block", 8'h00, {7'h0, o_main_write_block});
		// Lock write cut short mid-byte, then whole without write enable
		sotp_host_model_i.open_frame();
		sotp_host_model_i.byte_x(OP_WRITE_LOCK, q);
		sotp_host_model_i.byte_x(8'h02, q);
		for (int i = 0; i < 4; i++) sotp_host_model_i.bit_x(1'b1, q[0]);
		sotp_host_model_i.close_frame();
		check("status", 8'h00, o_lock_status);
		xfer(OP_WRDI, -1, 0);
		wq = {8'h02};
		xfer(OP_WRITE_LOCK, -1, 1);
		check("status", 8'h02, o_lock_status);
		// Locked region: only read-type opcodes and exit pass
		xfer(OP_ENTER_OTP, -1, 0);
		wq = {8'h00};
		foreach (lk[j])
		begin
			xfer(lk[j], adr[2], 1);
			rejects++;
		end
		wq = {};
		xfer(OP_READ, adr[2], 1);
		check("locked otp", 8'(mem[adr[2]]), rq[0]);
		xfer(OP_READ_SR1, -1, 1);
		xfer(OP_READ_LOCK, -1, 1);
		check("lock byte", 8'h02, rq[0]);
		check("rejects", 8'(rejects), 8'(seen_rej));
		xfer(OP_EXIT_OTP, -1, 0);
		check("mode", 8'h00, {7'h0, o_otp_mode});
		// Reset mid-run inside secure mode: volatile state lost, fuse still counts
		xfer(OP_ENTER_OTP, -1, 0);
		check("mode", 8'h01, {7'h0, o_otp_mode});
		i_resetn <= 1'b0;
		i_customer_lock_nv <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		check("status", 8'h02, o_lock_status);
		check("mode", 8'h00, {7'h0, o_otp_mode});
		wrap_up();
	end
endmodule
